// *** pie_pkg.sv ***
`default_nettype none
package pie_pkg;
    // Register map, byte addresses on the word-wide bus
    localparam logic [11:0] ADDR_ENABLE_1 = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_FLAGS = 12'h008;
    localparam logic [11:0] ADDR_REQUESTS = 12'h00c;
    // Enable bit positions
    localparam int BIT_TIMER1_OVF = 0;
    localparam int BIT_TIMER2_MATCH = 1;
    localparam int BIT_CAPCOMP1 = 2;
    localparam int BIT_SYNC_SERIAL = 3;
    localparam int BIT_SERIAL_TX = 4;
    localparam int BIT_SERIAL_RX = 5;
    localparam int BIT_ADC = 6;
    localparam int BIT_UNIMPL = 7;
    // Control register bit positions
    localparam int BIT_PRIORITY_MODE = 0;
    localparam int BIT_GROUP_GLOBAL = 1;
    // Reset values and masks
    localparam logic [7:0] ENABLE_1_RESET = 8'h00;
    localparam logic [7:0] ENABLE_1_IMPL_MASK = 8'h7f;
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic [7:0] enable_1;
        logic priority_mode_en;
        logic periph_group_global_en;
        logic pend_write;
        logic [11:0] pend_addr;
        logic [31:0] rdata;
    } pie_state_type;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } pie_ahb_req_type;
endpackage
`default_nettype wire

// *** pie_gate.sv ***
`timescale 1ns/10ps
`default_nettype none
module pie_gate #(
    parameter int WIDTH = 7
) (
    input wire logic [WIDTH-1:0] flag,
    input wire logic [WIDTH-1:0] enable,
    input wire logic group_open,
    output logic [WIDTH-1:0] request
);
    // Flags pass untouched; enables only gate the outgoing copy
    assign request = flag & enable & {WIDTH{group_open}};
endmodule // pie_gate
`default_nettype wire

// *** pie_enable.sv ***
// Overview of operation
// - Each peripheral request is forwarded only while its own enable bit is set.
// - With priority mode off, the group global enable must also be set.
// - Enable bit 7 is unimplemented: writes ignored, reads zero.
// - Bit 6 enables the converter completion interrupt.
// - Bit 5 enables the serial receiver interrupt.
// - Bit 4 enables the serial transmitter interrupt.
// - Bit 3 enables the synchronous serial port interrupt.
// - Bit 2 enables the capture/compare module 1 interrupt.
// - Bit 1 enables the second timer period-match interrupt.
// - Bit 0 enables the first timer overflow interrupt.
`timescale 1ns/10ps
`default_nettype none
module pie_enable (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic adc_flag,
    input wire logic serial_rx_flag,
    input wire logic serial_tx_flag,
    input wire logic sync_serial_flag,
    input wire logic capcomp1_flag,
    input wire logic timer2_match_flag,
    input wire logic timer1_ovf_flag,
    output logic adc_irq_req,
    output logic serial_rx_irq_req,
    output logic serial_tx_irq_req,
    output logic sync_serial_irq_req,
    output logic capcomp1_irq_req,
    output logic timer2_match_irq_req,
    output logic timer1_ovf_irq_req
);
    pie_pkg::pie_state_type state;
    pie_pkg::pie_state_type next_state;
    pie_pkg::pie_ahb_req_type bus;
    logic [6:0] flags;
    logic [6:0] requests;
    logic group_open;
    logic addr_phase;
    logic data_phase;
    logic hit_enable_1;
    logic hit_control;
    logic [7:0] enable_view;
    logic [1:0] control_view;
    logic [31:0] read_word;
    logic adc_irq_en;
    logic serial_rx_irq_en;
    logic serial_tx_irq_en;
    logic sync_serial_irq_en;
    logic capcomp1_irq_en;
    logic timer2_match_irq_en;
    logic timer1_ovf_irq_en;

    // Bundle the bus request
    assign bus = '{hsel, haddr, htrans, hwrite, hsize, hready, hwdata};
    assign addr_phase = bus.hsel && bus.hready && bus.htrans[1];

    // Flags in enable-bit order, bit 0 upward
    assign flags = {adc_flag, serial_rx_flag, serial_tx_flag, sync_serial_flag,
                    capcomp1_flag, timer2_match_flag, timer1_ovf_flag};

    // Per-source enable bits; bit 7 has no source behind it
    assign adc_irq_en = state.enable_1[pie_pkg::BIT_ADC];
    assign serial_rx_irq_en = state.enable_1[pie_pkg::BIT_SERIAL_RX];
    assign serial_tx_irq_en = state.enable_1[pie_pkg::BIT_SERIAL_TX];
    assign sync_serial_irq_en = state.enable_1[pie_pkg::BIT_SYNC_SERIAL];
    assign capcomp1_irq_en = state.enable_1[pie_pkg::BIT_CAPCOMP1];
    assign timer2_match_irq_en = state.enable_1[pie_pkg::BIT_TIMER2_MATCH];
    assign timer1_ovf_irq_en = state.enable_1[pie_pkg::BIT_TIMER1_OVF];

    // Group gate only matters while priority mode is off; with priority
    // mode on, gating per level belongs to the priority logic outside
    always_comb
    begin
        if (state.priority_mode_en)
        begin
            group_open = 1'b1;
        end
        else
        begin
            group_open = state.periph_group_global_en;
        end
    end

    pie_gate #(
        .WIDTH(7)
    ) u_gate (
        .flag(flags),
        .enable({adc_irq_en, serial_rx_irq_en, serial_tx_irq_en, sync_serial_irq_en,
                 capcomp1_irq_en, timer2_match_irq_en, timer1_ovf_irq_en}),
        .group_open(group_open),
        .request(requests)
    );

    // Each source takes its own enable bit
    assign adc_irq_req = requests[pie_pkg::BIT_ADC];
    assign serial_rx_irq_req = requests[pie_pkg::BIT_SERIAL_RX];
    assign serial_tx_irq_req = requests[pie_pkg::BIT_SERIAL_TX];
    assign sync_serial_irq_req = requests[pie_pkg::BIT_SYNC_SERIAL];
    assign capcomp1_irq_req = requests[pie_pkg::BIT_CAPCOMP1];
    assign timer2_match_irq_req = requests[pie_pkg::BIT_TIMER2_MATCH];
    assign timer1_ovf_irq_req = requests[pie_pkg::BIT_TIMER1_OVF];

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state.rdata;

    // A write commits only when its data phase ends with hready high,
    // so a stretched data phase cannot land stale write data
    assign data_phase = state.pend_write && bus.hready;
    assign hit_enable_1 = data_phase && (state.pend_addr == pie_pkg::ADDR_ENABLE_1);
    assign hit_control = data_phase && (state.pend_addr == pie_pkg::ADDR_CONTROL);

    // Register views with the landing write folded in; a read whose
    // address phase overlaps that data phase sees the new word
    always_comb
    begin
        enable_view = state.enable_1 & pie_pkg::ENABLE_1_IMPL_MASK;
        control_view = {state.periph_group_global_en, state.priority_mode_en};
        if (hit_enable_1)
        begin
            // Top bit is never stored
            enable_view = bus.hwdata[7:0] & pie_pkg::ENABLE_1_IMPL_MASK;
        end
        if (hit_control)
        begin
            control_view[pie_pkg::BIT_PRIORITY_MODE] = bus.hwdata[pie_pkg::BIT_PRIORITY_MODE];
            control_view[pie_pkg::BIT_GROUP_GLOBAL] = bus.hwdata[pie_pkg::BIT_GROUP_GLOBAL];
        end
    end

    // Read decode on the word index only:
    //   enable word, bits 6..0 writable, bit 7 reads zero
    //   control word, bit 0 priority mode, bit 1 group enable
    //   flag word and request word, read only
    //   anything else reads zero and ignores writes
    always_comb
    begin
        read_word = 32'h0000_0000;
        unique case ({bus.haddr[11:2], 2'b00})
            pie_pkg::ADDR_ENABLE_1:
            begin
                // Bit 7 reads zero
                read_word = {24'h00_0000, enable_view};
            end
            pie_pkg::ADDR_CONTROL:
            begin
                read_word = {30'h0000_0000, control_view};
            end
            pie_pkg::ADDR_FLAGS:
            begin
                // Raw flags, untouched by the enables
                read_word = {25'h000_0000, flags};
            end
            pie_pkg::ADDR_REQUESTS:
            begin
                read_word = {25'h000_0000, requests};
            end
            default:
            begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // Next state: commit a finished data phase, then capture read data
    // in the address phase; a stalled data phase keeps its write pending
    always_comb
    begin
        next_state = state;
        if (data_phase)
        begin
            // Writes to read-only or unmapped words commit nothing
            next_state.pend_write = 1'b0;
            if (hit_enable_1)
            begin
                next_state.enable_1 = enable_view;
            end
            if (hit_control)
            begin
                next_state.priority_mode_en = control_view[pie_pkg::BIT_PRIORITY_MODE];
                next_state.periph_group_global_en = control_view[pie_pkg::BIT_GROUP_GLOBAL];
            end
        end
        if (addr_phase)
        begin
            next_state.pend_write = bus.hwrite;
            next_state.pend_addr = {bus.haddr[11:2], 2'b00};
            // Write cycles leave zero on the read bus
            next_state.rdata = bus.hwrite ? 32'h0000_0000 : read_word;
        end
    end

    // State register; every enable starts masked
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state.enable_1 <= pie_pkg::ENABLE_1_RESET;
            state.priority_mode_en <= pie_pkg::CONTROL_RESET[pie_pkg::BIT_PRIORITY_MODE];
            state.periph_group_global_en <= pie_pkg::CONTROL_RESET[pie_pkg::BIT_GROUP_GLOBAL];
            state.pend_write <= 1'b0;
            state.pend_addr <= 12'h000;
            state.rdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
        end
    end
endmodule // pie_enable
`default_nettype wire

// *** pie_enable_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module pie_enable_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic adc_flag,
    input wire logic serial_rx_flag,
    input wire logic timer1_ovf_flag,
    input wire logic adc_irq_req,
    input wire logic serial_rx_irq_req,
    input wire logic timer1_ovf_irq_req
);
    logic wr_take;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Taken write; enables move on the next edge, so sampled requests change two edges later
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    sequence s_rd0; hsel && hready && htrans[1] && !hwrite && haddr[11:2] == 10'h000; endsequence
    property p_bit7; s_rd0 |=> hrdata[31:7] == 25'h0; endproperty
    a_bit7: assert property (p_bit7) else $error("enable readback above bit 6 set");
    property p_rst; $rose(hresetn) |-> !adc_irq_req && !serial_rx_irq_req && !timer1_ovf_irq_req; endproperty
    a_rst: assert property (p_rst) else $error("request out of reset");
    property p_adc; adc_irq_req |-> adc_flag; endproperty
    a_adc: assert property (p_adc) else $error("converter request without flag");
    property p_rx; serial_rx_irq_req |-> serial_rx_flag; endproperty
    a_rx: assert property (p_rx) else $error("receive request without flag");
    property p_t1; timer1_ovf_irq_req |-> timer1_ovf_flag; endproperty
    a_t1: assert property (p_t1) else $error("overflow request without flag");
    property p_hold; $stable(adc_flag) && !$past(wr_take, 2) |-> $stable(adc_irq_req); endproperty
    a_hold: assert property (p_hold) else $error("converter request moved alone");
    property p_rise; $rose(timer1_ovf_irq_req) |-> $rose(timer1_ovf_flag) || $past(wr_take, 2); endproperty
    a_rise: assert property (p_rise) else $error("overflow request rose alone");
    property p_fall; $fell(serial_rx_flag) |-> !serial_rx_irq_req; endproperty
    a_fall: assert property (p_fall) else $error("receive request outlived flag");
endmodule // pie_enable_props
bind pie_enable pie_enable_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .adc_flag(adc_flag),
    .serial_rx_flag(serial_rx_flag), .timer1_ovf_flag(timer1_ovf_flag), .adc_irq_req(adc_irq_req),
    .serial_rx_irq_req(serial_rx_irq_req), .timer1_ovf_irq_req(timer1_ovf_irq_req));
`default_nettype wire

// *** pie_enable_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module pie_enable_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp;
    logic [6:0] flg = 7'h00;
    logic [6:0] req, fr;
    logic [7:0] en;
    logic [1:0] ctl;
    integer seed = 32'he282;
    integer fail_count = 0;
    integer check_count = 0;
    pie_enable u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .adc_flag(flg[6]), .serial_rx_flag(flg[5]),
        .serial_tx_flag(flg[4]), .sync_serial_flag(flg[3]), .capcomp1_flag(flg[2]),
        .timer2_match_flag(flg[1]), .timer1_ovf_flag(flg[0]), .adc_irq_req(req[6]),
        .serial_rx_irq_req(req[5]), .serial_tx_irq_req(req[4]), .sync_serial_irq_req(req[3]),
        .capcomp1_irq_req(req[2]), .timer2_match_irq_req(req[1]), .timer1_ovf_irq_req(req[0]));
    // Free-running bus clock
    initial forever #2 hclk = ~hclk;
    // Gated requests; either control bit opens the group
    function automatic logic [31:0] exp_req(input logic [6:0] f, input logic [7:0] e, input logic [1:0] c);
        return 32'(f & e[6:0] & {7{|c}});
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait; a stuck slave ends the run
    task automatic wait_ready;
        int i;
        i = 0;
        do
        begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1)
        begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    // Write both words, then settle flags a cycle past the landing edge
    task automatic apply(input logic [7:0] e, input logic [1:0] c, input logic [6:0] f);
        bus(1'b1, 32'h0, 32'(e));
        bus(1'b1, 32'h4, 32'(c));
        flg <= f;
        @(posedge hclk);
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        flg <= 7'h7f;
        @(posedge hclk);
        chk(32'(req), 32'h0);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 32'h4, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 32'h0, 32'hffffffff);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h7f);
        $display("test reset_bit7 done");
        for (int i = 0; i < 7; i++)
        begin
            apply(8'h1 << i, 2'h2, 7'h7f);
            chk(32'(req), 32'h1 << i);
        end
        apply(8'h7f, 2'h0, 7'h7f);
        chk(32'(req), 32'h0);
        apply(8'h7f, 2'h1, 7'h7f);
        chk(32'(req), 32'h7f);
        $display("test bit_walk done");
        for (int i = 0; i < 40; i++)
        begin
            en = 8'($random(seed));
            ctl = 2'($random(seed));
            fr = 7'($random(seed));
            apply(en, ctl, fr);
            chk(32'(req), exp_req(fr, en, ctl));
            bus(1'b1, 32'h100, 32'hffffffff);
            bus(1'b1, 32'h8, 32'hffffffff);
            bus(1'b0, 32'h8, 32'h0);
            chk(rd, 32'(fr));
            bus(1'b0, 32'hc, 32'h0);
            chk(rd, exp_req(fr, en, ctl));
            bus(1'b0, 32'h4, 32'h0);
            chk(rd, 32'(ctl));
            bus(1'b0, 32'h0, 32'h0);
            chk(rd, 32'(en & 8'h7f));
            chk(32'(hresp), 32'h0);
        end
        $display("test random done");
        apply(8'h7f, 2'h2, 7'h7f);
        chk(32'(req), 32'h7f);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'(req), 32'h0);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 32'h4, 32'h0);
        chk(rd, 32'h0);
        $display("test second_reset done");
        close_out();
    end
endmodule // pie_enable_bench
`default_nettype wire
